// file: bench/line_timer.sv
`timescale 1ns/1ps
`default_nettype none
// stands in for the field logic: free-running pixel counter, odd and even lines in turn
module line_timer #(
    parameter int LINE_LEN = 48
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // line timing
    output logic line_start_o,
    output logic odd_line_o,
    output logic [12:0] h_count_o
);
    // counts move on the falling edge, so the design samples settled values
    always @(negedge clk_i) begin
        if (sys_rst_i) begin
            h_count_o <= 13'h0000;
            odd_line_o <= 1'b1;
        end else if (h_count_o == 13'(LINE_LEN - 1)) begin
            h_count_o <= 13'h0000;
            odd_line_o <= ~odd_line_o;
        end else begin
            h_count_o <= h_count_o + 13'h0001;
        end
    end

    // first pixel of every line
    assign line_start_o = (h_count_o == 13'h0000) && !sys_rst_i;
endmodule
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import horiz_pattern_pkg::*;
    localparam logic [4:0] ID = 5'h03;
    localparam int LEN = 48;
    localparam int LIMIT = 20000;
    typedef struct packed {
        logic is_look;
        logic [53:0] val;
        logic [53:0] care;
    } note_t;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic reg_we_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [11:0] reg_addr_i = 12'h000;
    logic [27:0] reg_wdata_i = 28'h0000000;
    logic seq_change_i = 1'b0;
    logic [4:0] region_pattern_select_i = 5'h00;
    logic clamp_set_select_i = 1'b0;
    logic pixblank_set_select_i = 1'b0;
    logic look = 1'b0;
    logic rd_seen = 1'b0;
    logic look_seen = 1'b0;
    logic line_start_i, odd_line_i, pattern_active_o, hblank_o;
    logic hclk_one_level_o, hclk_two_level_o, black_clamp_o, pixel_blank_o;
    logic [12:0] h_count_i, area_h1_count_o, area_h2_count_o;
    logic [27:0] reg_rdata_o;
    logic [53:0] obs;
    logic [2:0] alt_order_o;
    logic [1:0] repeat_area_o;
    logic [27:0] stage [16];
    logic [27:0] act [16] = '{default: 28'h0000000};
    logic act_on = 1'b0;
    logic csel = 1'b0;
    logic psel = 1'b0;
    note_t notes[$];
    note_t n;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;

    always #5 clk_i = ~clk_i;

    line_timer #(.LINE_LEN(LEN)) i_line_timer (.clk_i, .sys_rst_i,
        .line_start_o(line_start_i), .odd_line_o(odd_line_i), .h_count_o(h_count_i));

    horizontal_pattern_regs #(.PATTERN_ID(ID)) i_horizontal_pattern_regs (.clk_i, .sys_rst_i,
        .reg_we_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .line_start_i,
        .odd_line_i, .h_count_i, .seq_change_i, .region_pattern_select_i,
        .clamp_set_select_i, .pixblank_set_select_i, .pattern_active_o, .hblank_o,
        .hclk_one_level_o, .hclk_two_level_o, .black_clamp_o, .pixel_blank_o,
        .alt_order_o, .repeat_area_o, .area_h1_count_o, .area_h2_count_o);

    // all timing outputs gathered in one word so one note covers a cycle
    assign obs = {area_h1_count_o, area_h2_count_o, 17'h00000, repeat_area_o, alt_order_o,
                  pattern_active_o, hblank_o, hclk_one_level_o, hclk_two_level_o, black_clamp_o,
                  pixel_blank_o};

    task automatic check(input string what, input logic [53:0] seen, input logic [53:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // readable bits per word; the host keeps test and unused bits at zero
    function automatic logic [27:0] msk(input int o);
        case (o)
            7: return MASK_ONE;
            8: return MASK_MODE;
            9: return MASK_LENREP;
            11: return MASK_NONE;
            default: return MASK_TWO;
        endcase
    endfunction

    function automatic logic [12:0] fld(input int o, input int hi);
        return hi ? act[o][25:13] : act[o][12:0];
    endfunction

    // results land one edge later, so the monitor looks at the falling edge after
    always @(posedge clk_i) begin
        rd_seen <= reg_rd_i;
        look_seen <= look;
    end

    always @(negedge clk_i) begin
        if (rd_seen || look_seen) begin
            if (notes.size() == 0) begin
                check("note queue", 54'h1, 54'h0);
            end else begin
                n = notes.pop_front();
                if (n.is_look) begin
                    check("line outputs", obs & n.care, n.val & n.care);
                end else begin
                    check("read data", {26'h0, reg_rdata_o}, n.val);
                end
            end
        end
    end

    task automatic wr(input logic [11:0] a, input logic [27:0] d);
        @(negedge clk_i);
        reg_we_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clk_i);
        reg_we_i = 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [27:0] e);
        @(negedge clk_i);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        notes.push_back('{1'b0, {26'h0, e}, 54'hfffffff});
        @(negedge clk_i);
        reg_rd_i = 1'b0;
    endtask

    task automatic seq(input logic [4:0] sel, input logic cs, input logic ps);
        @(negedge clk_i);
        seq_change_i = 1'b1;
        region_pattern_select_i = sel;
        clamp_set_select_i = cs;
        pixblank_set_select_i = ps;
        act_on = (sel == ID);
        if (act_on) begin
            act = stage;
            csel = cs;
            psel = ps;
        end
        @(negedge clk_i);
        seq_change_i = 1'b0;
    endtask

    // full random words, or toggle positions inside the line with normal mode
    task automatic load(input bit full);
        logic [12:0] a, b;
        for (int o = 0; o < 16; o++) begin
            a = 13'(1 + $urandom % (LEN - 1));
            b = 13'(1 + $urandom % (LEN - 1));
            stage[o] = (full ? 28'($urandom) : {2'h0, b, a}) & msk(o);
            if (!full && o == 8) stage[o][19:18] = 2'h0;
            wr({8'h80, 4'(o)}, stage[o]);
        end
    endtask

    // notes the expected outputs for every pixel after the first of the next line of one parity
    task automatic run_line(input logic odd);
        logic hb, cl, pb, mix, hit;
        logic [2:0] alt;
        logic [1:0] md, area;
        int per, len, rep, st, en, base, ix;
        hb = 1'b0;
        cl = 1'b0;
        pb = 1'b0;
        md = act[8][19:18];
        mix = (md == 2'h1) || (md == 2'h2);
        len = (act[9][12:0] == 13'h0000) ? 1 : int'(act[9][12:0]);
        rep = (act[9][20:13] == 8'h00) ? 256 : int'(act[9][20:13]);
        st = int'(act[10][12:0]);
        en = int'(act[10][25:13]);
        base = odd ? 0 : 3;
        do @(posedge clk_i); while (!(h_count_i == 13'h0000 && odd_line_i === odd));
        for (int k = 1; k < LEN; k++) begin
            @(negedge clk_i);
            hit = 1'b0;
            for (int j = 0; j < 6; j++) hit |= (fld(base + j / 2, j % 2) == k);
            per = (k >= st) ? (k - st) / len : 0;
            if (md == 2'h0) hb ^= hit;
            else hb = mix && k >= st && k < en && per % 2 == 0 && per / 2 < rep;
            ix = (per / 2) % 6;
            alt = act[8][3 * ix +: 3];
            cl ^= (fld(csel ? 13 : 12, 0) == k) || (fld(csel ? 13 : 12, 1) == k);
            pb ^= (fld(psel ? 15 : 14, 0) == k) || (fld(psel ? 15 : 14, 1) == k);
            area = (md != 2'h2) ? 2'h0 : (k >= act[7][12:0]) ? 2'h3 :
                   (k >= act[6][25:13]) ? 2'h2 : (k >= act[6][12:0]) ? 2'h1 : 2'h0;
            look = 1'b1;
            if (act_on) begin
                notes.push_back('{1'b1, {fld(ix / 2, ix % 2), fld(3 + ix / 2, ix % 2), 17'h0,
                    area, alt, 1'b1, hb, act[9][21], act[9][22], cl, pb},
                    {{26{hb && md == 2'h2}}, 17'h0, 2'h3, {3{hb && mix}}, 2'h3, hb, hb, 2'h3}});
            end else begin
                // an idle pattern still shows its loaded first order field and clock levels
                notes.push_back('{1'b1, {45'h0, act[8][2:0], 2'h0, act[9][21], act[9][22], 2'h0},
                    '1});
            end
        end
        @(negedge clk_i);
        look = 1'b0;
    endtask

    // cuts a hang short
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            report_and_stop();
        end
    end

    initial begin
        void'($urandom(43));
        repeat (5) @(negedge clk_i);
        sys_rst_i = 1'b0;
        for (int o = 0; o < 16; o++) rd({8'h80, 4'(o)}, 28'h0000000);
        run_line(1'b1);
        load(1'b1);
        // outside the window: alias of offset zero must not be hit
        wr(12'h810, 28'($urandom));
        wr(12'h000, 28'($urandom));
        for (int o = 0; o < 16; o++) rd({8'h80, 4'(o)}, stage[o]);
        rd(12'h810, 28'h0000000);
        rd(12'h000, 28'h0000000);
        // staged only: outputs stay idle until a sequence change
        run_line(1'b0);
        load(1'b0);
        seq(ID, 1'b0, 1'b1);
        run_line(1'b1);
        run_line(1'b0);
        seq(ID, 1'b1, 1'b0);
        run_line(1'b1);
        seq(ID ^ 5'(1 + $urandom % 31), 1'b1, 1'b1);
        run_line(1'b0);
        // mixing, special mixing and the unused mode; length zero and count zero included
        for (int m = 1; m < 4; m++) begin
            stage[8] = {8'h00, 2'(m), 18'($urandom)};
            stage[9] = {5'h00, 2'($urandom), 8'(m == 1 ? 0 : 2), 13'(m == 1 ? 0 : 3)};
            stage[10] = {2'h0, 13'h0028, 13'h0006};
            stage[6] = {2'h0, 13'h0014, 13'h0008};
            stage[7] = 28'h000001e;
            for (int o = 6; o < 11; o++) wr({8'h80, 4'(o)}, stage[o]);
            seq(ID, 1'(m), ~1'(m));
            run_line(1'(m));
        end
        repeat (4) @(negedge clk_i);
        report_and_stop();
    end
endmodule
`default_nettype wire

// file: hdl/horiz_pattern_pkg.sv
`default_nettype none
package horiz_pattern_pkg;
    // address map: the pattern group always sits at this base
    localparam logic [11:0] BASE_ADDR = 12'h800;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 28;
    localparam int POS_W = 13;
    localparam int NUM_REGS = 16;
    localparam int IDX_W = 4;
    localparam int SEL_W = 5;

    // word offsets from the base
    localparam logic [3:0] OFF_ODD_12 = 4'h0;
    localparam logic [3:0] OFF_ODD_34 = 4'h1;
    localparam logic [3:0] OFF_ODD_56 = 4'h2;
    localparam logic [3:0] OFF_EVEN_12 = 4'h3;
    localparam logic [3:0] OFF_EVEN_34 = 4'h4;
    localparam logic [3:0] OFF_EVEN_56 = 4'h5;
    localparam logic [3:0] OFF_AREA_AB = 4'h6;
    localparam logic [3:0] OFF_AREA_C = 4'h7;
    localparam logic [3:0] OFF_MODE = 4'h8;
    localparam logic [3:0] OFF_LENREP = 4'h9;
    localparam logic [3:0] OFF_MIX = 4'ha;
    localparam logic [3:0] OFF_TEST = 4'hb;
    localparam logic [3:0] OFF_CLAMP0 = 4'hc;
    localparam logic [3:0] OFF_CLAMP1 = 4'hd;
    localparam logic [3:0] OFF_PBLK0 = 4'he;
    localparam logic [3:0] OFF_PBLK1 = 4'hf;

    // field positions
    localparam int LO_LSB = 0;
    localparam int HI_LSB = 13;
    localparam int ORDER_W = 3;
    localparam int MODE_LSB = 18;
    localparam int LEN_LSB = 0;
    localparam int REP_LSB = 13;
    localparam int REP_W = 8;
    localparam int MASK1_BIT = 21;
    localparam int MASK2_BIT = 22;
    localparam int NUM_TOGGLES = 6;
    localparam logic [2:0] LAST_ORDER = 3'h5;

    // readable bits per register; reserved and test bits read zero
    localparam logic [27:0] MASK_TWO = 28'h3ffffff;
    localparam logic [27:0] MASK_ONE = 28'h0001fff;
    localparam logic [27:0] MASK_MODE = 28'h00fffff;
    localparam logic [27:0] MASK_LENREP = 28'h07fffff;
    localparam logic [27:0] MASK_NONE = 28'h0000000;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_MIX = 2'b01,
        MODE_SPECIAL = 2'b10,
        MODE_UNUSED = 2'b11
    } blank_mode_t;

    typedef enum logic [1:0] {
        AREA_NONE = 2'b00,
        AREA_A = 2'b01,
        AREA_B = 2'b10,
        AREA_C = 2'b11
    } repeat_area_t;
endpackage
`default_nettype wire

// file: hdl/horizontal_pattern_regs.sv
// Summary of operation
// R1: pattern group decoded from base 0x800
// R2: writes staged, applied at sequence change
// R3: six odd-line toggle positions, two per word
// R4: six even-line toggle positions, two per word
// R5: toggle fields double as repeat-area counts
// R6: mode 2 uses repeat-area starts A,B,C
// R7: mode field selects normal, mixing, special
// R8: six order fields sequence blanking patterns
// R9: length and repeat count shape alternation
// R10: clock mask polarities held during blanking
// R11: mixing blanking bounded by start and end
// R12: two black-clamp toggle sets held
// R13: two pixel-blanking toggle sets held
// R14: host writes zero to test bits
// R15: host writes zero to unused bits
// R16: sequence change positions switch active values
// R17: region selector picks which pattern governs
// R18: per-sequence bit picks clamp toggle set
// R19: blanking flips on matches, starts inactive
`timescale 1ns/1ps
`default_nettype none
module horizontal_pattern_regs #(
    parameter logic [4:0] PATTERN_ID = 5'h00
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // register write/read port from the serial decoder
    input wire logic reg_we_i,
    input wire logic reg_rd_i,
    input wire logic [horiz_pattern_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [horiz_pattern_pkg::DATA_W-1:0] reg_wdata_i,
    output logic [horiz_pattern_pkg::DATA_W-1:0] reg_rdata_o,
    // line timing from the vertical/field logic
    input wire logic line_start_i,
    input wire logic odd_line_i,
    input wire logic [horiz_pattern_pkg::POS_W-1:0] h_count_i,
    input wire logic seq_change_i,
    input wire logic [horiz_pattern_pkg::SEL_W-1:0] region_pattern_select_i,
    input wire logic clamp_set_select_i,
    input wire logic pixblank_set_select_i,
    // timing outputs
    output logic pattern_active_o,
    output logic hblank_o,
    output logic hclk_one_level_o,
    output logic hclk_two_level_o,
    output logic black_clamp_o,
    output logic pixel_blank_o,
    // alternation status
    output logic [2:0] alt_order_o,
    output logic [1:0] repeat_area_o,
    output logic [horiz_pattern_pkg::POS_W-1:0] area_h1_count_o,
    output logic [horiz_pattern_pkg::POS_W-1:0] area_h2_count_o
);
    import horiz_pattern_pkg::*;

    typedef struct packed {
        logic [NUM_REGS-1:0][DATA_W-1:0] stage;
        logic [NUM_REGS-1:0][DATA_W-1:0] active;
        logic [DATA_W-1:0] rdata;
        logic selected;
        logic clamp_sel;
        logic pixel_blanking_pulse_sel;
        logic blank;
        logic mix_run;
        logic [POS_W-1:0] phase;
        logic [REP_W-1:0] rep;
        logic [2:0] alt_idx;
        logic [2:0] alt_order;
        logic [1:0] area;
        logic [POS_W-1:0] h1_count;
        logic [POS_W-1:0] h2_count;
    } pattern_state_t;

    pattern_state_t st_q;
    pattern_state_t st_d;

    // true when the address falls in this pattern's sixteen words
    function automatic logic in_window(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:IDX_W] == BASE_ADDR[ADDR_W-1:IDX_W];
    endfunction

    // writable/readable bits; the test word and bit never reach logic
    function automatic logic [DATA_W-1:0] reg_mask(input logic [IDX_W-1:0] idx);
        logic [DATA_W-1:0] m;
        m = MASK_TWO;
        if (idx == OFF_AREA_C) begin
            m = MASK_ONE;
        end else if (idx == OFF_MODE) begin
            m = MASK_MODE;
        end else if (idx == OFF_LENREP) begin
            m = MASK_LENREP;
        end else if (idx == OFF_TEST) begin
            m = MASK_NONE;
        end
        return m;
    endfunction

    // one 13-bit position from the low or high half of a word
    function automatic logic [POS_W-1:0] pos_field(input logic [DATA_W-1:0] w,
                                                   input logic hi);
        return hi ? w[HI_LSB +: POS_W] : w[LO_LSB +: POS_W];
    endfunction

    // toggle field k (0..5) from the odd or even bank
    function automatic logic [POS_W-1:0] toggle_pos(
        input logic [NUM_REGS-1:0][DATA_W-1:0] regs, input logic odd,
        input logic [2:0] k);
        logic [IDX_W-1:0] base;
        base = odd ? OFF_ODD_12 : OFF_EVEN_12;
        return pos_field(regs[base + IDX_W'(k[2:1])], k[0]);
    endfunction

    logic [IDX_W-1:0] wr_idx;
    blank_mode_t mode;
    logic toggle_hit;
    logic [POS_W-1:0] mix_start;
    logic [POS_W-1:0] mix_end;
    logic [POS_W-1:0] blank_len;
    logic [REP_W-1:0] rep_count;
    logic [POS_W-1:0] area_a;
    logic [POS_W-1:0] area_b;
    logic [POS_W-1:0] area_c;
    logic load;

    always_comb begin
        wr_idx = reg_addr_i[IDX_W-1:0];
        mode = blank_mode_t'(st_q.active[OFF_MODE][MODE_LSB +: 2]); // R7
        mix_start = pos_field(st_q.active[OFF_MIX], 1'b0); // R11
        mix_end = pos_field(st_q.active[OFF_MIX], 1'b1);
        blank_len = st_q.active[OFF_LENREP][LEN_LSB +: POS_W]; // R9
        rep_count = st_q.active[OFF_LENREP][REP_LSB +: REP_W];
        area_a = pos_field(st_q.active[OFF_AREA_AB], 1'b0); // R6
        area_b = pos_field(st_q.active[OFF_AREA_AB], 1'b1);
        area_c = pos_field(st_q.active[OFF_AREA_C], 1'b0);
        load = seq_change_i && (region_pattern_select_i == PATTERN_ID); // R17
        toggle_hit = 1'b0;
        for (int k = 0; k < NUM_TOGGLES; k++) begin
            if (toggle_pos(st_q.active, odd_line_i, 3'(k)) == h_count_i) begin // R3 R4
                toggle_hit = 1'b1;
            end
        end
    end

    // register file, staging and sequence-change transfer
    always_comb begin
        st_d = st_q;
        if (reg_we_i && in_window(reg_addr_i)) begin // R1
            st_d.stage[wr_idx] = reg_wdata_i & reg_mask(wr_idx); // R14 R15
        end
        if (reg_rd_i) begin
            st_d.rdata = in_window(reg_addr_i) ?
                (st_q.stage[wr_idx] & reg_mask(wr_idx)) : '0;
        end
        // a write in the same cycle as the change waits for the next one
        if (seq_change_i) begin // R16
            st_d.selected = load;
            if (load) begin
                st_d.active = st_q.stage; // R2
                st_d.clamp_sel = clamp_set_select_i; // R18
                st_d.pixel_blanking_pulse_sel = pixblank_set_select_i;
            end
        end

        // blanking generator
        if (line_start_i || !st_q.selected) begin
            st_d.blank = 1'b0; // R19
            st_d.mix_run = 1'b0;
            st_d.alt_idx = '0;
        end else begin
            unique case (mode)
                MODE_NORMAL: begin
                    if (toggle_hit) begin
                        st_d.blank = !st_q.blank; // R19
                    end
                end
                MODE_MIX, MODE_SPECIAL: begin
                    if (h_count_i == mix_start) begin // R11
                        st_d.mix_run = 1'b1;
                        st_d.blank = 1'b1;
                        st_d.phase = '0;
                        st_d.rep = '0;
                        st_d.alt_idx = '0;
                    end else if (h_count_i == mix_end) begin
                        st_d.mix_run = 1'b0;
                        st_d.blank = 1'b0;
                    end else if (st_q.mix_run) begin
                        // blank and gap each last one length; a zero length acts as one
                        if (st_q.phase + 13'h0001 >= blank_len) begin // R9
                            st_d.phase = '0;
                            st_d.blank = !st_q.blank;
                            if (!st_q.blank) begin
                                st_d.alt_idx = (st_q.alt_idx == LAST_ORDER) ?
                                    3'h0 : st_q.alt_idx + 3'h1; // R8
                            end
                            if (st_q.blank) begin
                                st_d.rep = st_q.rep + 8'h01;
                                if (st_q.rep + 8'h01 == rep_count) begin
                                    st_d.mix_run = 1'b0;
                                    st_d.blank = 1'b0;
                                end
                            end
                        end else begin
                            st_d.phase = st_q.phase + 13'h0001;
                        end
                    end
                end
                MODE_UNUSED: begin
                    st_d.blank = 1'b0; // R7
                    st_d.mix_run = 1'b0;
                end
            endcase
        end
        // follow the index being entered, so the order shown matches the blank shown
        st_d.alt_order =
            st_q.active[OFF_MODE][ORDER_W*st_d.alt_idx +: ORDER_W]; // R8

        // repeat areas and their per-clock counts in special mixing
        st_d.area = AREA_NONE;
        st_d.h1_count = '0;
        st_d.h2_count = '0;
        if (st_q.selected && mode == MODE_SPECIAL) begin
            if (h_count_i >= area_c) begin // R6
                st_d.area = AREA_C;
            end else if (h_count_i >= area_b) begin
                st_d.area = AREA_B;
            end else if (h_count_i >= area_a) begin
                st_d.area = AREA_A;
            end
            st_d.h1_count = toggle_pos(st_q.active, 1'b1, st_d.alt_idx); // R5
            st_d.h2_count = toggle_pos(st_q.active, 1'b0, st_d.alt_idx);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // clamp and pixel-blanking pulses use the set latched at the change
    toggle_pulse_gen u_clamp (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .enable_i(st_q.selected),
        .line_start_i(line_start_i),
        .h_count_i(h_count_i),
        .toggle_one_i(pos_field(st_q.active[st_q.clamp_sel ? OFF_CLAMP1 : OFF_CLAMP0],
                                1'b0)), // R12
        .toggle_two_i(pos_field(st_q.active[st_q.clamp_sel ? OFF_CLAMP1 : OFF_CLAMP0],
                                1'b1)),
        .pulse_o(black_clamp_o)
    );

    toggle_pulse_gen u_pixel_blanking_pulse (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .enable_i(st_q.selected),
        .line_start_i(line_start_i),
        .h_count_i(h_count_i),
        .toggle_one_i(pos_field(st_q.active[st_q.pixel_blanking_pulse_sel ? OFF_PBLK1 : OFF_PBLK0],
                                1'b0)), // R13
        .toggle_two_i(pos_field(st_q.active[st_q.pixel_blanking_pulse_sel ? OFF_PBLK1 : OFF_PBLK0],
                                1'b1)),
        .pulse_o(pixel_blank_o)
    );

    // outputs straight from flops; clock levels only matter while blanked
    assign reg_rdata_o = st_q.rdata;
    assign pattern_active_o = st_q.selected;
    assign hblank_o = st_q.blank;
    assign hclk_one_level_o = st_q.active[OFF_LENREP][MASK1_BIT]; // R10
    assign hclk_two_level_o = st_q.active[OFF_LENREP][MASK2_BIT]; // R10
    assign alt_order_o = st_q.alt_order;
    assign repeat_area_o = st_q.area;
    assign area_h1_count_o = st_q.h1_count;
    assign area_h2_count_o = st_q.h2_count;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_base_write;
        reg_we_i && reg_addr_i == BASE_ADDR && !seq_change_i
            |=> st_q.stage[0] == ($past(reg_wdata_i) & MASK_TWO);
    endproperty
    a_base_write: assert property (p_base_write) else $error("base write lost"); // R1

    property p_hold_until_change;
        !seq_change_i |=> $stable(st_q.active);
    endproperty
    a_hold_until_change: assert property (p_hold_until_change) else $error("early apply"); // R2

    property p_apply_at_change;
        load |=> st_q.active == $past(st_q.stage) && pattern_active_o;
    endproperty
    a_apply_at_change: assert property (p_apply_at_change) else $error("not applied"); // R16

    property p_odd_toggle;
        st_q.selected && mode == MODE_NORMAL && !line_start_i && odd_line_i && toggle_hit
            |=> hblank_o != $past(hblank_o);
    endproperty
    a_odd_toggle: assert property (p_odd_toggle) else $error("odd toggle missed"); // R3

    property p_even_toggle;
        st_q.selected && mode == MODE_NORMAL && !line_start_i && !odd_line_i
            && !toggle_hit && !seq_change_i |=> $stable(hblank_o);
    endproperty
    a_even_toggle: assert property (p_even_toggle) else $error("spurious toggle"); // R4

    property p_line_start;
        line_start_i |=> !hblank_o;
    endproperty
    a_line_start: assert property (p_line_start) else $error("line not inactive"); // R19

    property p_unused_mode;
        mode == MODE_UNUSED && !seq_change_i ##1 mode == MODE_UNUSED |-> !hblank_o;
    endproperty
    a_unused_mode: assert property (p_unused_mode) else $error("mode 3 blanked"); // R7

    property p_mix_end;
        st_q.selected && (mode == MODE_MIX || mode == MODE_SPECIAL) && !line_start_i
            && h_count_i == mix_end && h_count_i != mix_start |=> !hblank_o;
    endproperty
    a_mix_end: assert property (p_mix_end) else $error("blank past end"); // R11

    property p_order_range;
        st_q.alt_idx <= LAST_ORDER;
    endproperty
    a_order_range: assert property (p_order_range) else $error("order index overrun"); // R8

    property p_area_c;
        st_q.selected && mode == MODE_SPECIAL && h_count_i >= area_c
            |=> repeat_area_o == AREA_C;
    endproperty
    a_area_c: assert property (p_area_c) else $error("area C missed"); // R6

    property p_clamp_sel;
        load |=> st_q.clamp_sel == $past(clamp_set_select_i);
    endproperty
    a_clamp_sel: assert property (p_clamp_sel) else $error("clamp set not latched"); // R18

    c_load: cover property (load ##1 hblank_o);
    c_mix_run: cover property (st_q.mix_run && st_q.rep == 8'h02);
    c_area_b: cover property (repeat_area_o == AREA_B ##1 repeat_area_o == AREA_C);
    c_clamp: cover property (st_q.clamp_sel && black_clamp_o);
endmodule
`default_nettype wire

// file: hdl/toggle_pulse_gen.sv
`timescale 1ns/1ps
`default_nettype none
module toggle_pulse_gen (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // line timing
    input wire logic enable_i,
    input wire logic line_start_i,
    input wire logic [horiz_pattern_pkg::POS_W-1:0] h_count_i,
    // toggle positions
    input wire logic [horiz_pattern_pkg::POS_W-1:0] toggle_one_i,
    input wire logic [horiz_pattern_pkg::POS_W-1:0] toggle_two_i,
    // pulse
    output logic pulse_o
);
    import horiz_pattern_pkg::*;

    typedef struct packed {
        logic level;
    } pulse_state_t;

    pulse_state_t st_q;
    pulse_state_t st_d;
    logic hit;

    // every line starts inactive; equal positions flip only once
    always_comb begin
        st_d = st_q;
        hit = (h_count_i == toggle_one_i) || (h_count_i == toggle_two_i);
        if (line_start_i || !enable_i) begin
            st_d.level = 1'b0;
        end else if (hit) begin
            st_d.level = !st_q.level;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pulse_o = st_q.level;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_pulse_toggle;
        enable_i && !line_start_i && hit |=> pulse_o != $past(pulse_o);
    endproperty
    a_pulse_toggle: assert property (p_pulse_toggle) else $error("pulse missed toggle"); // R12

    property p_pulse_line_start;
        line_start_i |=> !pulse_o ##1 (!pulse_o || $past(hit));
    endproperty
    a_pulse_line_start: assert property (p_pulse_line_start) else $error("pulse not cleared"); // R13
endmodule
`default_nettype wire
